// ---- fsf_pkg.sv ----
// constants and types shared by the fail and reset signalling block
package fsf_pkg;

	// ==================================================
	// clock and timing
	localparam longint CLOCK_HZ = 20_000_000;
	localparam longint BLINK_FREQ_MILLIHZ = 1250;
	localparam longint DIM_FREQ_HZ = 100;
	localparam longint TEST_FILTER_US = 64;
	localparam longint RESET_FILTER_US = 10;
	localparam longint RESET_DELAY_US = 10_000;

	// longest half period rounds down, least filter times round up
	localparam longint BLINK_HALF_CYCLES = (CLOCK_HZ * 1000) / (2 * BLINK_FREQ_MILLIHZ);
	localparam longint DIM_PERIOD_CYCLES = CLOCK_HZ / DIM_FREQ_HZ;
	localparam longint TEST_FILTER_CYCLES = (TEST_FILTER_US * CLOCK_HZ + 999_999) / 1_000_000;
	localparam longint RESET_FILTER_CYCLES = (RESET_FILTER_US * CLOCK_HZ + 999_999) / 1_000_000;
	localparam longint RESET_DELAY_CYCLES = (RESET_DELAY_US * CLOCK_HZ + 999_999) / 1_000_000;

	// ==================================================
	// dim duty select encodings, divisor of the dim period
	localparam logic [1:0] DUTY_20 = 2'h0;
	localparam logic [1:0] DUTY_10 = 2'h1;
	localparam logic [1:0] DUTY_5 = 2'h2;
	localparam logic [1:0] DUTY_2P5 = 2'h3;
	localparam int DUTY_DIV_20 = 5;
	localparam int DUTY_DIV_10 = 10;
	localparam int DUTY_DIV_5 = 20;
	localparam int DUTY_DIV_2P5 = 40;

	// ==================================================
	// modes and pin configurations
	typedef enum logic [2:0] {
		MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE, MODE_DEVELOP
	} fsf_mode_type;

	typedef enum logic [2:0] {
		PIN_FAIL, PIN_OFF, PIN_WAKE, PIN_LOWSIDE, PIN_HIGHSIDE
	} fsf_pin_cfg_type;

	typedef enum logic [1:0] {
		RS_LOW, RS_DELAY, RS_HIGH
	} fsf_reset_state_type;

	// ==================================================
	// values after reset
	localparam fsf_pin_cfg_type PIN_CFG_RESET = PIN_FAIL;
	localparam logic SW_ON_RESET = 1'h0;
	localparam logic [1:0] DUTY_RESET = DUTY_20;
	localparam logic SOFT_RO_RESET = 1'h1;
	localparam logic [1:0] UV_THRESHOLD_RESET = 2'h0;
	localparam logic TEST_LEVEL_RESET = 1'h1;

endpackage

// ---- fsf_level_filter.sv ----
// stability filter: a level is accepted only after it stands unchanged long enough
`timescale 1ns/1ps
module fsf_level_filter #(
	parameter int STABLE_CYCLES = 1280,
	parameter logic RESET_LEVEL = 1'h1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic level_in,
	output logic level_out
);
	localparam int CW = $clog2(STABLE_CYCLES + 1);

	if (STABLE_CYCLES < 1) begin : g_bad_count
		$error("fsf_level_filter needs STABLE_CYCLES of at least one");
	end

	logic [CW-1:0] cnt_q;
	logic level_q;
	wire differs = level_in != level_q;
	wire done = cnt_q == CW'(STABLE_CYCLES - 1);

	assign level_out = level_q;

	// a glitch shorter than the window restarts the count
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			level_q <= RESET_LEVEL;
		end else if (!differs) begin
			cnt_q <= '0;
		end else if (done) begin
			cnt_q <= '0;
			level_q <= level_in;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end
endmodule // fsf_level_filter

// ---- fsf_pattern_gen.sv ----
// blink and dim waveform generators for the fail pins
`timescale 1ns/1ps
module fsf_pattern_gen #(
	parameter int BLINK_HALF = 8_000_000,
	parameter int DIM_PERIOD = 200_000
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic enable,
	input wire logic [1:0] duty_sel,
	output logic blink_on,
	output logic dim_on
);
	import fsf_pkg::*;

	localparam int BW = $clog2(BLINK_HALF + 1);
	localparam int DW = $clog2(DIM_PERIOD + 1);

	if (BLINK_HALF < 2 || DIM_PERIOD < DUTY_DIV_2P5) begin : g_bad_period
		$error("fsf_pattern_gen periods too short for the duty settings");
	end

	function automatic int on_length(input logic [1:0] sel);
		int len;
		len = DIM_PERIOD / DUTY_DIV_20;
		if (sel == DUTY_10) begin
			len = DIM_PERIOD / DUTY_DIV_10;
		end else if (sel == DUTY_5) begin
			len = DIM_PERIOD / DUTY_DIV_5;
		end else if (sel == DUTY_2P5) begin
			len = DIM_PERIOD / DUTY_DIV_2P5;
		end
		return len;
	endfunction

	logic [BW-1:0] blink_cnt_q;
	logic blink_phase_q;
	logic [DW-1:0] dim_cnt_q;
	wire blink_wrap = blink_cnt_q == BW'(BLINK_HALF - 1);
	wire dim_wrap = dim_cnt_q == DW'(DIM_PERIOD - 1);

	assign blink_on = enable && blink_phase_q;
	assign dim_on = enable && (int'(dim_cnt_q) < on_length(duty_sel));

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			blink_cnt_q <= '0;
			blink_phase_q <= 1'h1;
		end else if (!enable) begin
			blink_cnt_q <= '0;
			blink_phase_q <= 1'h1;
		end else if (blink_wrap) begin
			blink_cnt_q <= '0;
			blink_phase_q <= !blink_phase_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + BW'(1);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dim_cnt_q <= '0;
		end else if (!enable || dim_wrap) begin
			dim_cnt_q <= '0;
		end else begin
			dim_cnt_q <= dim_cnt_q + DW'(1);
		end
	end
endmodule // fsf_pattern_gen

// ---- fsf_fail_reset.sv ----
// fail output, alternate pin, test input and reset output control
//
// Summary of operation
// - pin configuration writes accepted only in normal
// - stop and sleep keep last configuration
// - failure entry drives fail outputs active
// - wake pin off in fail-safe only
// - switches off in restart and fail-safe
// - fail output stays active into normal
// - blink output 1.25 Hz, half duty
// - dim output 100 Hz, selectable duty
// - test level accepted after 64 us stable
// - reset low after filter, plus delay
// - reset starts low, released after delay
// - watchdog failure also asserts reset
// - undervoltage threshold selectable, lowest by default
// - soft reset returns init, restores defaults
// - soft reset pulses reset unless configured not
// - soft reset ignored outside normal and stop
// - dim duty 20, 10, 5, 2.5 percent
// - fail released after conditions and flag cleared
`timescale 1ns/1ps
module fsf_fail_reset #(
	parameter int BLINK_HALF_CYC = int'(fsf_pkg::BLINK_HALF_CYCLES),
	parameter int DIM_PERIOD_CYC = int'(fsf_pkg::DIM_PERIOD_CYCLES),
	parameter int RESET_DELAY_CYC = int'(fsf_pkg::RESET_DELAY_CYCLES)
) (
	input wire logic clock,
	input wire logic rst,
	// chip mode from the mode controller
	input wire fsf_pkg::fsf_mode_type chip_mode,
	// settings written by the host
	input wire logic settings_write,
	input wire fsf_pkg::fsf_pin_cfg_type blink_pin_cfg,
	input wire fsf_pkg::fsf_pin_cfg_type dim_pin_cfg,
	input wire logic blink_switch_on,
	input wire logic dim_switch_on,
	input wire logic [1:0] dim_duty_select,
	input wire logic soft_reset_pulses_reset_out,
	input wire logic [1:0] reset_threshold_select,
	input wire logic soft_reset_cmd,
	// failure sources
	input wire logic failure_event,
	input wire logic failure_present,
	input wire logic failure_flag_clear,
	input wire logic watchdog_fail,
	input wire logic main_regulator_uv,
	// pins
	input wire logic blink_fail_in,
	input wire logic dim_fail_test_in,
	output logic static_fail_out_n,
	output logic blink_fail_out,
	output logic blink_fail_oe_n,
	output logic dim_fail_test_out,
	output logic dim_fail_test_oe_n,
	output logic reset_out_pin_n,
	// status to the rest of the chip
	output logic blink_wake_enable,
	output logic dim_wake_enable,
	output logic blink_pin_level,
	output logic test_level,
	output logic failure_flag,
	output logic soft_reset_take,
	output logic [1:0] uv_threshold_sel,
	output logic [1:0] dim_duty_active
);
	import fsf_pkg::*;

	localparam int FILTER_CYC = int'(RESET_FILTER_CYCLES);
	localparam int TEST_CYC = int'(TEST_FILTER_CYCLES);

	if (RESET_DELAY_CYC < 1 || FILTER_CYC < 1) begin : g_bad_reset
		$error("fsf_fail_reset reset times must be at least one cycle");
	end

	// ==================================================
	// pin input synchronisers
	logic [2:0] async_in;
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	assign async_in = {main_regulator_uv, dim_fail_test_in, blink_fail_in};

	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				sync1_q[i] <= 1'h1;
				sync2_q[i] <= 1'h1;
			end else begin
				sync1_q[i] <= async_in[i];
				sync2_q[i] <= sync1_q[i];
			end
		end
	end

	wire blink_in_s = sync2_q[0];
	wire test_in_s = sync2_q[1];
	wire uv_s = sync2_q[2];

	// ==================================================
	// settings
	fsf_pin_cfg_type blink_cfg_q;
	fsf_pin_cfg_type dim_cfg_q;
	logic blink_sw_q;
	logic dim_sw_q;
	logic [1:0] duty_q;
	logic soft_ro_q;
	logic [1:0] uv_thr_q;

	wire in_normal = chip_mode == MODE_NORMAL;
	wire in_restart_fs = chip_mode == MODE_RESTART || chip_mode == MODE_FAILSAFE;
	wire settings_take = settings_write && in_normal;
	wire soft_valid = soft_reset_cmd && (in_normal || chip_mode == MODE_STOP);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			blink_cfg_q <= PIN_CFG_RESET;
			dim_cfg_q <= PIN_CFG_RESET;
			blink_sw_q <= SW_ON_RESET;
			dim_sw_q <= SW_ON_RESET;
			duty_q <= DUTY_RESET;
			soft_ro_q <= SOFT_RO_RESET;
			uv_thr_q <= UV_THRESHOLD_RESET;
		end else if (soft_valid) begin
			blink_cfg_q <= PIN_CFG_RESET;
			dim_cfg_q <= PIN_CFG_RESET;
			blink_sw_q <= SW_ON_RESET;
			dim_sw_q <= SW_ON_RESET;
			duty_q <= DUTY_RESET;
			soft_ro_q <= SOFT_RO_RESET;
			uv_thr_q <= UV_THRESHOLD_RESET;
		end else if (settings_take) begin
			blink_cfg_q <= blink_pin_cfg;
			dim_cfg_q <= dim_pin_cfg;
			blink_sw_q <= blink_switch_on;
			dim_sw_q <= dim_switch_on;
			duty_q <= dim_duty_select;
			soft_ro_q <= soft_reset_pulses_reset_out;
			uv_thr_q <= reset_threshold_select;
		end
	end

	// ==================================================
	// failure latch
	logic fail_q;
	// release needs clear and no condition
	wire fail_release = failure_flag_clear && in_normal && !failure_present;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fail_q <= 1'h0;
		end else if (failure_event) begin
			fail_q <= 1'h1;
		end else if (fail_release || soft_valid) begin
			fail_q <= 1'h0;
		end
	end

	// ==================================================
	// waveforms and test filter
	logic blink_on;
	logic dim_on;
	logic test_filt;

	fsf_pattern_gen #(
		.BLINK_HALF(BLINK_HALF_CYC),
		.DIM_PERIOD(DIM_PERIOD_CYC)
	) u_pattern (
		.clock(clock),
		.rst(rst),
		.enable(fail_q),
		.duty_sel(duty_q),
		.blink_on(blink_on),
		.dim_on(dim_on)
	);

	fsf_level_filter #(
		.STABLE_CYCLES(TEST_CYC),
		.RESET_LEVEL(TEST_LEVEL_RESET)
	) u_test_filter (
		.clock(clock),
		.rst(rst),
		.level_in(test_in_s),
		.level_out(test_filt)
	);

	// ==================================================
	// pin drive, returns {out, oe_n}; oe_n low means driving
	function automatic logic [1:0] pin_drive(input fsf_pin_cfg_type cfg, input logic fail_on, input logic sw_on,
			input logic switch_block);
		logic [1:0] drv;
		drv = 2'h1;
		if (cfg == PIN_FAIL) begin
			drv = fail_on ? 2'h0 : 2'h1;
		end else if (cfg == PIN_LOWSIDE) begin
			drv = (sw_on && !switch_block) ? 2'h0 : 2'h1;
		end else if (cfg == PIN_HIGHSIDE) begin
			drv = (sw_on && !switch_block) ? 2'h2 : 2'h1;
		end
		return drv;
	endfunction

	// blink pattern on the blink pin
	// switches blocked in restart and fail-safe
	wire [1:0] blink_drv = pin_drive(blink_cfg_q, blink_on, blink_sw_q, in_restart_fs);
	// dim pattern on the dim pin
	wire [1:0] dim_drv = pin_drive(dim_cfg_q, dim_on, dim_sw_q, in_restart_fs);
	// wake stays through restart, off in fail-safe
	wire blink_wake_d = blink_cfg_q == PIN_WAKE && chip_mode != MODE_FAILSAFE;
	wire dim_wake_d = dim_cfg_q == PIN_WAKE && chip_mode != MODE_FAILSAFE;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			static_fail_out_n <= 1'h1;
			blink_fail_out <= 1'h0;
			blink_fail_oe_n <= 1'h1;
			dim_fail_test_out <= 1'h0;
			dim_fail_test_oe_n <= 1'h1;
			blink_wake_enable <= 1'h0;
			dim_wake_enable <= 1'h0;
		end else begin
			static_fail_out_n <= !fail_q;
			blink_fail_out <= blink_drv[1];
			blink_fail_oe_n <= blink_drv[0];
			dim_fail_test_out <= dim_drv[1];
			dim_fail_test_oe_n <= dim_drv[0];
			blink_wake_enable <= blink_wake_d;
			dim_wake_enable <= dim_wake_d;
		end
	end

	// ==================================================
	// reset output sequencer
	fsf_reset_state_type rs_q;
	fsf_reset_state_type rs_d;
	logic [31:0] rs_cnt_q;
	logic [31:0] rs_cnt_d;
	wire filter_done = rs_cnt_q == 32'(FILTER_CYC - 1);
	wire delay_done = rs_cnt_q == 32'(RESET_DELAY_CYC - 1);
	wire soft_pulse = soft_valid && soft_ro_q;
	wire pulse_req = watchdog_fail || soft_pulse;

	always_comb begin
		rs_d = rs_q;
		rs_cnt_d = rs_cnt_q + 32'h1;
		case (rs_q)
			RS_HIGH: begin
				if (pulse_req) begin
					rs_d = RS_DELAY;
					rs_cnt_d = '0;
				end else if (!uv_s) begin
					rs_cnt_d = '0;
				end else if (filter_done) begin
					rs_d = RS_LOW;
					rs_cnt_d = '0;
				end
			end
			RS_LOW: begin
				rs_cnt_d = '0;
				if (!uv_s) begin
					rs_d = RS_DELAY;
				end
			end
			RS_DELAY: begin
				if (uv_s) begin
					rs_d = RS_LOW;
					rs_cnt_d = '0;
				end else if (pulse_req) begin
					rs_cnt_d = '0;
				end else if (delay_done) begin
					rs_d = RS_HIGH;
					rs_cnt_d = '0;
				end
			end
			default: begin
				rs_d = RS_LOW;
				rs_cnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rs_q <= RS_LOW;
			rs_cnt_q <= '0;
			reset_out_pin_n <= 1'h0;
		end else begin
			rs_q <= rs_d;
			rs_cnt_q <= rs_cnt_d;
			reset_out_pin_n <= rs_d == RS_HIGH;
		end
	end

	// ==================================================
	// status
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			blink_pin_level <= 1'h1;
			test_level <= TEST_LEVEL_RESET;
			failure_flag <= 1'h0;
			soft_reset_take <= 1'h0;
			uv_threshold_sel <= UV_THRESHOLD_RESET;
			dim_duty_active <= DUTY_RESET;
		end else begin
			blink_pin_level <= blink_in_s;
			test_level <= test_filt;
			failure_flag <= fail_q;
			// tells the mode controller to go to init
			soft_reset_take <= soft_valid;
			uv_threshold_sel <= uv_thr_q;
			dim_duty_active <= duty_q;
		end
	end
endmodule // fsf_fail_reset

// ---- fsf_fail_reset_props.sv ----
// port-level assertions for the fail and reset signalling block
`timescale 1ns/1ps
module fsf_fail_reset_props
	import fsf_pkg::*;
#(
	parameter int RESET_DELAY_CYC = 10
) (
	input wire logic clock,
	input wire logic rst,
	input wire fsf_pkg::fsf_mode_type chip_mode,
	input wire logic settings_write,
	input wire logic [1:0] dim_duty_select,
	input wire logic [1:0] reset_threshold_select,
	input wire logic soft_reset_cmd,
	input wire logic failure_event,
	input wire logic failure_present,
	input wire logic failure_flag_clear,
	input wire logic watchdog_fail,
	input wire logic main_regulator_uv,
	input wire logic static_fail_out_n,
	input wire logic blink_fail_out,
	input wire logic blink_fail_oe_n,
	input wire logic dim_fail_test_out,
	input wire logic dim_fail_test_oe_n,
	input wire logic reset_out_pin_n,
	input wire logic blink_wake_enable,
	input wire logic dim_wake_enable,
	input wire logic failure_flag,
	input wire logic soft_reset_take,
	input wire logic [1:0] uv_threshold_sel,
	input wire logic [1:0] dim_duty_active
);
	// ==================================================
	// helpers
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	int low_q;
	// counts low samples of the reset output since it last stood high
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			low_q <= 0;
		end else begin
			low_q <= reset_out_pin_n ? 0 : low_q + 1;
		end
	end
	sequence s_taken;
		settings_write && chip_mode == MODE_NORMAL && !soft_reset_cmd;
	endsequence
	sequence s_quiet;
		!(settings_write && chip_mode == MODE_NORMAL) && !soft_reset_cmd;
	endsequence
	// ==================================================
	// assertions
	a_write_taken: assert property (s_taken |-> ##2 dim_duty_active == $past(dim_duty_select, 2)
		&& uv_threshold_sel == $past(reset_threshold_select, 2)) else $error("settings write not applied");
	a_settings_held: assert property (s_quiet [*3] |=> $stable(dim_duty_active) && $stable(uv_threshold_sel))
		else $error("settings changed without a taken write");
	a_soft_taken: assert property (soft_reset_cmd && chip_mode inside {MODE_NORMAL, MODE_STOP} |=> soft_reset_take)
		else $error("valid soft reset not taken");
	a_soft_ignored: assert property (soft_reset_cmd && !(chip_mode inside {MODE_NORMAL, MODE_STOP})
		|=> !soft_reset_take) else $error("soft reset taken in wrong mode");
	a_soft_defaults: assert property (soft_reset_take |=> dim_duty_active == DUTY_RESET
		&& uv_threshold_sel == UV_THRESHOLD_RESET) else $error("soft reset did not restore defaults");
	a_fail_set: assert property (failure_event |-> ##2 failure_flag) else $error("failure not latched");
	a_static_flag: assert property (static_fail_out_n == !failure_flag) else $error("static fail out wrong");
	a_flag_release: assert property ($fell(failure_flag) |-> ($past(failure_flag_clear, 2)
		&& !$past(failure_present, 2) && $past(chip_mode, 2) == MODE_NORMAL)
		|| $past(soft_reset_cmd, 2) || $past(soft_reset_cmd, 3)) else $error("failure released early");
	a_failsafe_wake: assert property (chip_mode == MODE_FAILSAFE [*2] |-> !blink_wake_enable && !dim_wake_enable)
		else $error("wake left on in fail-safe");
	a_switch_off: assert property (chip_mode inside {MODE_RESTART, MODE_FAILSAFE} [*2]
		|-> (blink_fail_oe_n || !blink_fail_out) && (dim_fail_test_oe_n || !dim_fail_test_out))
		else $error("high-side on in restart");
	a_reset_min: assert property ($rose(reset_out_pin_n) |-> low_q >= RESET_DELAY_CYC)
		else $error("reset released before delay");
	a_uv_filter: assert property ($rose(main_regulator_uv) && reset_out_pin_n && !watchdog_fail
		|=> reset_out_pin_n [*8]) else $error("reset filter too short");
	a_wd_reset: assert property (watchdog_fail |-> ##[1:3] !reset_out_pin_n) else $error("no watchdog reset");
endmodule // fsf_fail_reset_props

bind fsf_fail_reset fsf_fail_reset_props #(.RESET_DELAY_CYC(RESET_DELAY_CYC)) u_props (.clock(clock), .rst(rst),
	.chip_mode(chip_mode), .settings_write(settings_write), .dim_duty_select(dim_duty_select),
	.reset_threshold_select(reset_threshold_select), .soft_reset_cmd(soft_reset_cmd), .failure_event(failure_event),
	.failure_present(failure_present), .failure_flag_clear(failure_flag_clear), .watchdog_fail(watchdog_fail),
	.main_regulator_uv(main_regulator_uv), .static_fail_out_n(static_fail_out_n), .blink_fail_out(blink_fail_out),
	.blink_fail_oe_n(blink_fail_oe_n), .reset_out_pin_n(reset_out_pin_n), .blink_wake_enable(blink_wake_enable),
	.dim_fail_test_out(dim_fail_test_out), .dim_fail_test_oe_n(dim_fail_test_oe_n),
	.dim_wake_enable(dim_wake_enable), .failure_flag(failure_flag), .soft_reset_take(soft_reset_take),
	.uv_threshold_sel(uv_threshold_sel), .dim_duty_active(dim_duty_active));

// ---- fsf_host_model.sv ----
// host side: pulled-up pins, soft reset strobe and reset pulse timing
`timescale 1ns/1ps
module fsf_host_model (
	input wire logic clock,
	input wire logic reset_out_pin_n,
	input wire logic soft_req,
	input wire logic test_drive,
	input wire logic dim_oe_n,
	input wire logic dim_out,
	input wire logic blink_oe_n,
	input wire logic blink_out,
	output logic soft_reset_cmd,
	output logic dim_pin,
	output logic blink_pin,
	output int low_len
);
	int cnt = 0;
	assign soft_reset_cmd = soft_req;
	// test pin held high unless driven low on purpose; pull-ups when released
	assign dim_pin = !dim_oe_n ? dim_out : !test_drive;
	assign blink_pin = !blink_oe_n ? blink_out : 1'h1;
	initial low_len = 0;
	// length of the last finished low pulse on the reset line
	always @(posedge clock) begin
		if (!reset_out_pin_n) begin
			cnt <= cnt + 1;
		end else begin
			if (cnt != 0) low_len <= cnt;
			cnt <= 0;
		end
	end
endmodule // fsf_host_model

// ---- tb_fail_and_reset_signalling.sv ----
// self-checking testbench of the fail and reset signalling block
`timescale 1ns/1ps
module tb_fail_and_reset_signalling;
	import fsf_pkg::*;
	localparam int DLY = 10;
	localparam int DIM_P = 80;
	logic clock, rst, sw, swd, blev, sro, soft_req, test_drive, ev, pres, fclr, wdf, uv, srcmd, dpin, bpin;
	fsf_mode_type mode;
	fsf_pin_cfg_type bcfg, dcfg;
	logic [1:0] duty, thr, uvsel, dact;
	logic sfo_n, bout, boe_n, dout, doe_n, ro_n, bwk, dwk, tlev, fflag, take;
	int low_len, errors = 0, check_count = 0, n, i;
	fsf_mode_type mtab [4] = '{MODE_STOP, MODE_RESTART, MODE_FAILSAFE, MODE_NORMAL};

	fsf_fail_reset #(.BLINK_HALF_CYC(8), .DIM_PERIOD_CYC(DIM_P), .RESET_DELAY_CYC(DLY)) DUT (.clock(clock), .rst(rst),
		.chip_mode(mode), .settings_write(sw), .blink_pin_cfg(bcfg), .dim_pin_cfg(dcfg), .blink_switch_on(swd),
		.dim_switch_on(swd), .dim_duty_select(duty), .soft_reset_pulses_reset_out(sro),
		.reset_threshold_select(thr), .soft_reset_cmd(srcmd), .failure_event(ev), .failure_present(pres),
		.failure_flag_clear(fclr), .watchdog_fail(wdf), .main_regulator_uv(uv), .blink_fail_in(bpin),
		.dim_fail_test_in(dpin), .static_fail_out_n(sfo_n), .blink_fail_out(bout), .blink_fail_oe_n(boe_n),
		.dim_fail_test_out(dout), .dim_fail_test_oe_n(doe_n), .reset_out_pin_n(ro_n), .blink_wake_enable(bwk),
		.dim_wake_enable(dwk), .blink_pin_level(blev), .test_level(tlev), .failure_flag(fflag),
		.soft_reset_take(take), .uv_threshold_sel(uvsel), .dim_duty_active(dact));
	fsf_host_model host (.clock(clock), .reset_out_pin_n(ro_n), .soft_req(soft_req), .test_drive(test_drive),
		.dim_oe_n(doe_n), .dim_out(dout), .blink_oe_n(boe_n), .blink_out(bout), .soft_reset_cmd(srcmd),
		.dim_pin(dpin), .blink_pin(bpin), .low_len(low_len));

	initial begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end

	// ==================================================
	// tasks
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clock);
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		@(negedge clock);
		s = 1'h0;
	endtask
	task automatic write(input fsf_pin_cfg_type b, d, input logic on, input logic [1:0] du, input logic s, t);
		bcfg = b; dcfg = d; swd = on; duty = du; sro = s; thr = {1'h0, t};
		pulse(sw);
		cyc(2);
	endtask
	// skips a running phase, then counts one whole phase where oe_n equals lvl
	task automatic phase(input bit dim, input logic lvl, output int k);
		int g;
		g = 0;
		while ((dim ? doe_n : boe_n) === lvl && g < 500) begin @(negedge clock); g++; end
		while ((dim ? doe_n : boe_n) !== lvl && g < 500) begin @(negedge clock); g++; end
		k = 0;
		while ((dim ? doe_n : boe_n) === lvl && k < 500) begin @(negedge clock); k++; end
	endtask
	function automatic int dim_low(input int c);
		return DIM_P / (c == 0 ? DUTY_DIV_20 : c == 1 ? DUTY_DIV_10 : c == 2 ? DUTY_DIV_5 : DUTY_DIV_2P5);
	endfunction
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#(50 * 20000);
		errors++;
		end_of_test;
	end

	// ==================================================
	// main sequence
	initial begin
		rst = 1; mode = MODE_INIT; sw = 0; bcfg = PIN_FAIL; dcfg = PIN_FAIL; swd = 0; duty = 0; sro = 1; thr = 0;
		soft_req = 0; test_drive = 0; ev = 0; pres = 0; fclr = 0; wdf = 0; uv = 0;
		void'($urandom(72314));
		cyc(20);
		rst = 0;
		check("reset_out", ro_n, 0);
		check("uv_sel", uvsel, 0);
		cyc(20);
		check("reset_out", ro_n, 1);
		mode = MODE_NORMAL;
		for (i = 0; i < 4; i++) begin
			write(PIN_FAIL, PIN_FAIL, 0, i[1:0], 1, 1'($urandom));
			check("duty", dact, i);
			check("uv_sel", uvsel, thr);
			pres = 1;
			pulse(ev);
			cyc(1);
			check("blink_start", boe_n, 0);
			check("dim_start", doe_n, 0);
			if (i == 0) begin
				phase(0, 0, n);
				check("blink_low", n, 8);
				check("blink_level_low", blev, 0);
				phase(0, 1, n);
				check("blink_high", n, 8);
				check("blink_level_high", blev, 1);
			end
			phase(1, 0, n); check("dim_low", n, dim_low(i));
			check("static", sfo_n, 0);
			pulse(fclr); cyc(3); check("flag_present", fflag, 1);
			pres = 0;
			pulse(fclr); cyc(3); check("flag_cleared", fflag, 0);
			check("blink_released", boe_n, 1);
		end
		mode = MODE_STOP;
		write(PIN_FAIL, PIN_FAIL, 0, 2'h0, 1, 1);
		check("refused", dact, 3);
		mode = MODE_NORMAL;
		write(PIN_WAKE, PIN_HIGHSIDE, 1, 2'h1, 1, 0);
		for (i = 0; i < 4; i++) begin
			mode = mtab[i];
			cyc(3);
			check("wake", bwk, i != 2);
			check("dim_wake", dwk, 0);
			check("hs_oe_n", doe_n, i == 1 || i == 2);
			check("hs_out", dout, i == 0 || i == 3);
		end
		write(PIN_OFF, PIN_OFF, 0, 2'h1, 1, 0);
		test_drive = 1;
		cyc(1000); check("test_short", tlev, 1);
		cyc(300); check("test_long", tlev, 0);
		test_drive = 0;
		cyc(1300); check("test_back", tlev, 1);
		pulse(soft_req);
		check("soft_take", take, 1);
		cyc(DLY + 5);
		check("soft_pulse", low_len, DLY);
		check("soft_default", dact, DUTY_RESET);
		write(PIN_FAIL, PIN_FAIL, 0, 2'h2, 0, 0);
		pulse(soft_req);
		for (i = 0; i < 14; i++) begin
			cyc(1); check("soft_no_pulse", ro_n, 1);
		end
		write(PIN_FAIL, PIN_FAIL, 0, 2'h2, 1, 0);
		mode = MODE_SLEEP;
		pulse(soft_req);
		check("soft_refused", take, 0);
		cyc(1);
		mode = MODE_FAILSAFE; pulse(soft_req);
		cyc(DLY + 5);
		check("soft_ignored", dact, 2);
		check("soft_ignored_ro", ro_n, 1);
		mode = MODE_NORMAL;
		pulse(wdf); cyc(DLY + 5);
		check("wd_pulse", low_len, DLY);
		uv = 1;
		cyc(150); check("uv_filter", ro_n, 1);
		cyc(100); check("uv_low", ro_n, 0);
		uv = 0;
		cyc(6); check("uv_delay", ro_n, 0);
		cyc(14); check("uv_release", ro_n, 1);
		end_of_test;
	end
endmodule // tb_fail_and_reset_signalling
